// >>> bench/four_level_interrupt_priority_controller_tb_top.sv
`timescale 1ns/1ps
`include "ilpc_map.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module four_level_interrupt_priority_controller_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [12:0] src_flags = 13'h0;
   logic ext0_edge_mode = 1'b0;
   logic ext1_edge_mode = 1'b0;
   logic rc_clock_sel = 1'b0;
   logic power_down = 1'b0;
   logic [12:0] flag_clear;
   logic wake_req;
   logic [15:0] last_vec;
   logic [1:0] last_lvl;
   logic [12:0] last_clr;
   logic en [13];
   logic [1:0] lvl [13];
   logic ge_m;
   int svc_q [$];
   int ncall = 0;
   int sp_m, calls_m = 0, miscompares = 0, num_checks = 0;
   localparam logic [15:0] VEC [13] = '{16'h0003, 16'h002B, 16'h0053, 16'h000B, 16'h0033,
      16'h005B, 16'h0013, 16'h003B, 16'h0063, 16'h001B, 16'h0043, 16'h0023, 16'h0073};
   localparam int BP [13] = '{0, 5, 4, 1, 0, 6, 2, 1, 2, 3, 3, 4, 5};

   always #2 pclk = ~pclk;

   ilpc_if ilpc_if_inst ();
   ilpc_ctrl ilpc_ctrl_inst (.pclk(pclk), .presetn(presetn), .core(ilpc_if_inst),
      .src_flags(src_flags), .ext0_edge_mode(ext0_edge_mode), .ext1_edge_mode(ext1_edge_mode),
      .rc_clock_sel(rc_clock_sel), .power_down(power_down), .flag_clear(flag_clear),
      .wake_req(wake_req));
   ilpc_core ilpc_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ctl(ilpc_if_inst));
   ilpc_checker ilpc_checker_inst (.pclk(pclk), .presetn(presetn),
      .mc_tick(ilpc_if_inst.mc_tick), .last_cycle(ilpc_if_inst.last_cycle),
      .block_call(ilpc_if_inst.block_call), .return_from_interrupt_exec(ilpc_if_inst.return_from_interrupt_exec),
      .call_req(ilpc_if_inst.call_req), .call_vector(ilpc_if_inst.call_vector),
      .call_level(ilpc_if_inst.call_level), .in_service(ilpc_if_inst.in_service));

   // Flag clears share the call cycle, so capture both together
   always @(posedge pclk) begin
      if (ilpc_if_inst.call_req === 1'b1) begin
         ncall <= ncall + 1;
         last_vec <= ilpc_if_inst.call_vector;
         last_lvl <= ilpc_if_inst.call_level;
         last_clr <= flag_clear;
      end
   end

   task automatic end_sim;
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Pending clears when the instruction is loaded, not when it ends, so a trailing
   // plain instruction is posted: its load marks the end of the real one
   task automatic instr(input logic [1:0] op, input logic [2:0] idx, input logic [7:0] d);
      logic [31:0] r;
      for (int n = 0; n < 2; n++) begin
         apb(1'b1, `ILPC_APB_INSTR, (n == 0) ? {8'h00, d, 5'h00, idx, 6'h00, op} : 32'h0, r);
         do apb(1'b0, `ILPC_APB_STATUS, 32'h0, r); while (r[24] !== 1'b0);
      end
   endtask : instr

   task automatic cfg;
      logic [7:0] b [6];
      int g;
      foreach (b[j]) b[j] = 8'h00;
      for (int i = 0; i < 13; i++) begin
         g = int'((13'h1594 >> i) & 13'h1);
         b[g][BP[i]] = en[i];
         b[2 + 2 * g][BP[i]] = lvl[i][0];
         b[3 + 2 * g][BP[i]] = lvl[i][1];
      end
      b[0][7] = ge_m;
      for (int j = 0; j < 6; j++) instr(2'h1, 3'(j), b[j]);
   endtask : cfg

   function automatic logic [3:0] inserv;
      logic [3:0] m = 4'h0;
      foreach (svc_q[i]) m[svc_q[i]] = 1'b1;
      return m;
   endfunction : inserv

   task automatic stat;
      logic [31:0] r;
      apb(1'b0, `ILPC_APB_STATUS, 32'h0, r);
      `CHK(r[15:12], inserv())
      `CHK(r[10:8], 3'(sp_m))
   endtask : stat

   task automatic serve(input logic [12:0] f);
      int w, n0, top;
      logic [12:0] clr;
      w = -1;
      for (int i = 0; i < 13; i++) if (ge_m && f[i] && en[i] && (w < 0 || lvl[i] > lvl[w])) w = i;
      top = svc_q.size() > 0 ? svc_q[$] : -1;
      n0 = ncall;
      src_flags <= f;
      repeat (40) @(posedge pclk);
      src_flags <= 13'h0;
      if (w >= 0 && int'(lvl[w]) > top) begin
         clr = 13'h0;
         if (w == 3 || w == 9 || (w == 0 && ext0_edge_mode) || (w == 6 && ext1_edge_mode))
            clr[w] = 1'b1;
         `CHK(ncall - n0, 1)
         `CHK(last_vec, VEC[w])
         `CHK(last_lvl, lvl[w])
         `CHK(last_clr, clr)
         svc_q.push_back(int'(lvl[w]));
         sp_m = (sp_m + 1) % 8;
         calls_m++;
      end else `CHK(ncall - n0, 0)
   endtask : serve

   task automatic retire(input logic [1:0] op);
      instr(op, 3'h0, 8'h00);
      // An empty stack is not popped
      if (sp_m != 0) sp_m--;
      if (op == 2'h2 && svc_q.size() > 0) void'(svc_q.pop_back());
      stat();
   endtask : retire

   initial begin
      #200000;
      miscompares++;
      end_sim();
   end

   initial begin
      logic [31:0] r;
      int k;
      void'($urandom(32'h493bfcaa));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h10, 32'h0, r);
      `CHK(r, 32'h0)
      apb(1'b0, `ILPC_APB_STATUS, 32'h0, r);
      sp_m = 0;
      `CHK(r, 32'h0)
      apb(1'b1, `ILPC_APB_CTRL, 32'h101, r);
      ge_m = 1'b1;
      foreach (en[i]) begin
         en[i] = 1'b1;
         lvl[i] = 2'h0;
      end
      cfg();
      for (k = 0; k < 13; k++) begin
         serve(13'h1 << k);
         retire(2'h2);
      end
      serve(13'h1FFF);
      retire(2'h2);
      $display("TEST vectors done");
      foreach (lvl[i]) lvl[i] = 2'h1;
      lvl[12] = 2'h2;
      lvl[11] = 2'h3;
      cfg();
      serve(13'h0020);
      serve(13'h0001);
      serve(13'h1000);
      retire(2'h3);
      serve(13'h0800);
      serve(13'h1FFF);
      repeat (3) retire(2'h2);
      $display("TEST preemption done");
      for (k = 0; k < 30; k++) begin
         foreach (en[i]) begin
            en[i] = 1'($urandom);
            lvl[i] = 2'($urandom);
         end
         ge_m = ($urandom % 4) != 0;
         ext0_edge_mode <= 1'($urandom);
         ext1_edge_mode <= 1'($urandom);
         apb(1'b1, `ILPC_APB_CTRL, 32'h100 | ($urandom % 3 + 1), r);
         cfg();
         serve(13'($urandom));
         serve(13'($urandom));
         while (svc_q.size() > 0) retire(2'h2);
      end
      apb(1'b0, `ILPC_APB_CALLS, 32'h0, r);
      `CHK(r[7:0], 8'(calls_m))
      $display("TEST random done");
      foreach (en[i]) en[i] = 1'b1;
      ge_m = 1'b1;
      cfg();
      power_down <= 1'b1;
      for (k = 0; k < 26; k++) begin
         rc_clock_sel <= (k >= 13);
         src_flags <= 13'h1 << (k % 13);
         repeat (3) @(posedge pclk);
         `CHK(wake_req, 1'(((k >= 13) ? 13'h05E7 : 13'h05C3) >> (k % 13)))
         src_flags <= 13'h0;
         repeat (3) @(posedge pclk);
         `CHK(wake_req, 1'b0)
      end
      $display("TEST wake done");
      end_sim();
   end
endmodule : four_level_interrupt_priority_controller_tb_top

// >>> bench/ilpc_checker.sv
`timescale 1ns/1ps

module ilpc_checker
   import ilpc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Core to controller
   input wire logic mc_tick,
   input wire logic last_cycle,
   input wire logic block_call,
   input wire logic return_from_interrupt_exec,
   // Controller to core
   input wire logic call_req,
   input wire ilpc_addr_t call_vector,
   input wire ilpc_level_t call_level,
   input wire logic [3:0] in_service
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Only the top level ends, lower nested levels stay active
   function automatic logic [3:0] drop_top(input logic [3:0] v);
      return v[3] ? (v & 4'h7) : v[2] ? (v & 4'h3) : v[1] ? (v & 4'h1) : 4'h0;
   endfunction : drop_top

   property p_last; call_req |-> $past(mc_tick && last_cycle); endproperty
   a_last: assert property (p_last) else $error("call off last cycle");
   property p_block; call_req |-> !$past(block_call); endproperty
   a_block: assert property (p_block) else $error("call during blocked instr");
   property p_gap; call_req |=> !call_req [*8]; endproperty
   a_gap: assert property (p_gap) else $error("call inside call sequence");
   property p_mark; call_req |-> in_service[call_level]; endproperty
   a_mark: assert property (p_mark) else $error("level not marked in service");
   property p_preempt; call_req |-> ($past(in_service) >> call_level) == 4'h0; endproperty
   a_preempt: assert property (p_preempt) else $error("call not above service");
   property p_vec; call_req |-> call_vector[2:0] == 3'h3 && call_vector <= 16'h0073; endproperty
   a_vec: assert property (p_vec) else $error("vector out of table");
   property p_return_from_interrupt; return_from_interrupt_exec |=> in_service == drop_top($past(in_service)); endproperty
   a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return did not end top level");
   property p_hold; $changed(in_service) |-> call_req || $past(return_from_interrupt_exec); endproperty
   a_hold: assert property (p_hold) else $error("service state moved alone");
   property p_vhold; !call_req |-> $stable(call_vector) && $stable(call_level); endproperty
   a_vhold: assert property (p_vhold) else $error("vector moved without call");

   c_top: cover property (call_req && call_level == 2'h3);
   c_nest: cover property (call_req && $past(in_service) != 4'h0);
   c_return_from_interrupt: cover property (return_from_interrupt_exec && in_service[1]);
endmodule : ilpc_checker

// >>> core/ilpc_core.sv
`timescale 1ns/1ps
`include "ilpc_map.svh"

module ilpc_core
   import ilpc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Controller link
   ilpc_if.core ctl
);

   ilpc_core_state_t state_q;
   logic [1:0] mc_cnt_q;
   logic [3:0] instr_cnt_q;
   logic [3:0] instr_len_q;
   logic run_q;
   ilpc_op_t cur_op_q;
   ilpc_op_t pend_op_q;
   logic pend_q;
   logic [2:0] pend_addr_q;
   logic [7:0] pend_data_q;
   logic [2:0] cur_addr_q;
   logic [7:0] cur_data_q;
   logic [2:0] call_cnt_q;
   ilpc_addr_t pc_q;
   ilpc_addr_t stack_q [0:7];
   logic [2:0] sp_q;
   logic full_q;
   logic [7:0] calls_q;
   logic [31:0] prdata_q;
   logic [31:0] rd_mux;

   wire logic mc_tick;
   wire logic [3:0] len_m1;
   wire logic last;
   wire logic instr_end;
   wire logic apb_wr;
   wire logic do_pop;
   wire logic can_pop;

   assign mc_tick = mc_cnt_q == `ILPC_MC_CLOCKS;
   assign len_m1 = (instr_len_q == 4'h0) ? 4'h0 : instr_len_q - 4'h1;
   // R08: final machine cycle flagged
   assign last = run_q & (state_q == ILPC_EXEC) & (instr_cnt_q == len_m1);
   assign instr_end = mc_tick & last;
   assign can_pop = full_q | (sp_q != 3'h0);
   // R17: both returns pop the stack
   assign do_pop = instr_end & ((cur_op_q == ILPC_OP_RETURN_FROM_INTERRUPT) | (cur_op_q == ILPC_OP_RET))
                 & can_pop;
   assign apb_wr = psel & penable & pwrite;

   assign ctl.mc_tick = mc_tick;
   assign ctl.last_cycle = last;
   // R09: enable/priority writes and return-from-interrupt block
   assign ctl.block_call = last & ((cur_op_q == ILPC_OP_SFR_WRITE) | (cur_op_q == ILPC_OP_RETURN_FROM_INTERRUPT));
   // R17: report return-from-interrupt
   assign ctl.return_from_interrupt_exec = instr_end & (cur_op_q == ILPC_OP_RETURN_FROM_INTERRUPT);
   assign ctl.sfr_we = instr_end & (cur_op_q == ILPC_OP_SFR_WRITE);
   assign ctl.sfr_addr = cur_addr_q;
   assign ctl.sfr_wdata = cur_data_q;

   always_comb begin
      unique case (paddr)
         `ILPC_APB_CTRL: rd_mux = {23'h0, run_q, 4'h0, instr_len_q};
         `ILPC_APB_INSTR: rd_mux = {8'h0, pend_data_q, 5'h0, pend_addr_q, 6'h0, pend_op_q};
         `ILPC_APB_STATUS: rd_mux = {7'h0, pend_q, ctl.sfr_rdata, ctl.in_service,
                                     state_q == ILPC_CALL, sp_q, pc_q[7:0]};
         `ILPC_APB_CALLS: rd_mux = {24'h0, calls_q};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data is captured in setup, so no wait states
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = prdata_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         run_q <= 1'b0;
         instr_len_q <= `ILPC_RST_INSTR_LEN;
      end else begin
         if (psel && !penable) begin
            prdata_q <= rd_mux;
         end
         if (apb_wr && paddr == `ILPC_APB_CTRL) begin
            instr_len_q <= pwdata[3:0];
            run_q <= pwdata[8];
         end
      end
   end

   // Instruction sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ILPC_EXEC;
         mc_cnt_q <= 2'h0;
         instr_cnt_q <= 4'h0;
         cur_op_q <= ILPC_OP_PLAIN;
         cur_addr_q <= 3'h0;
         cur_data_q <= 8'h00;
         pend_op_q <= ILPC_OP_PLAIN;
         pend_q <= 1'b0;
         pend_addr_q <= 3'h0;
         pend_data_q <= 8'h00;
         call_cnt_q <= 3'h0;
         pc_q <= 16'h0000;
         sp_q <= 3'h0;
         full_q <= 1'b0;
         calls_q <= 8'h00;
      end else begin
         mc_cnt_q <= mc_tick ? 2'h0 : mc_cnt_q + 2'h1;
         if (apb_wr && paddr == `ILPC_APB_INSTR) begin
            pend_op_q <= ilpc_op_t'(pwdata[1:0]);
            pend_addr_q <= pwdata[10:8];
            pend_data_q <= pwdata[23:16];
            pend_q <= 1'b1;
         end else if (instr_end) begin
            pend_q <= 1'b0;
         end
         if (instr_end) begin
            instr_cnt_q <= 4'h0;
            cur_op_q <= pend_q ? pend_op_q : ILPC_OP_PLAIN;
            cur_addr_q <= pend_addr_q;
            cur_data_q <= pend_data_q;
            if (do_pop) begin
               pc_q <= stack_q[sp_q - 3'h1];
               sp_q <= sp_q - 3'h1;
               full_q <= 1'b0;
            end else begin
               pc_q <= pc_q + 16'h0001;
            end
         end else if (mc_tick && state_q == ILPC_EXEC && run_q) begin
            instr_cnt_q <= instr_cnt_q + 4'h1;
         end
         unique case (state_q)
            ILPC_EXEC: begin
               // R15: push return address, load vector
               if (ctl.call_req) begin
                  state_q <= ILPC_CALL;
                  call_cnt_q <= `ILPC_CALL_MCYCLES;
                  stack_q[sp_q] <= pc_q;
                  sp_q <= sp_q + 3'h1;
                  full_q <= sp_q == 3'h7;
                  pc_q <= ctl.call_vector;
                  calls_q <= calls_q + 8'h01;
               end
            end
            ILPC_CALL: begin
               // R21: call occupies four machine cycles
               if (mc_tick) begin
                  call_cnt_q <= call_cnt_q - 3'h1;
                  if (call_cnt_q == 3'h1) begin
                     state_q <= ILPC_EXEC;
                  end
               end
            end
         endcase
      end
   end

endmodule : ilpc_core

// >>> core/ilpc_ctrl.sv
// Overview of operation
// R01: Two priority bits map to levels 0-3
// R02: Each source level set independently, paired bits
// R03: Only strictly higher level preempts running service
// R04: Higher level wins among simultaneous requests
// R05: Fixed thirteen-entry ranking breaks level ties
// R06: Sample, poll, resolve within one machine cycle
// R07: No call while equal/higher level in service
// R08: Call only on instruction's last machine cycle
// R09: No call on enable/priority write or return-from-interrupt
// R10: Requests never latched; each poll fresh
// R11: Timer overflow flags cleared on vectoring
// R12: External flags cleared only when edge-triggered
// R13: Serial receive/transmit flags never cleared here
// R14: Watchdog flag left set; software clears
// R15: Call pushes program counter, loads vector
// R16: Fixed vector address per source
// R17: Return-from-interrupt ends current in-service state
// R18: Plain return leaves in-service state untouched
// R19: Per-source enables plus global enable mask
// R20: Power-down wake set per source, RC-gated
// R21: Hardware call lasts four machine cycles
// R22: One in-service bit per priority level
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "ilpc_map.svh"

module ilpc_ctrl
   import ilpc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Core sequencer
   ilpc_if.ctrl core,
   // Source flags, indexed by arbitration rank
   input wire logic [12:0] src_flags,
   // Source configuration
   input wire logic ext0_edge_mode,
   input wire logic ext1_edge_mode,
   input wire logic rc_clock_sel,
   input wire logic power_down,
   // Flag clear pulses back to the sources, by rank
   output logic [12:0] flag_clear,
   // Power-down wake request
   output logic wake_req
);

   // R05: ranking order fixed
   localparam int SRC_BIT [0:12] = '{
      `ILPC_BIT_EXT0, `ILPC_BIT_BROWNOUT, `ILPC_BIT_WDOG, `ILPC_BIT_TIMER0,
      `ILPC_BIT_I2C, `ILPC_BIT_CONV, `ILPC_BIT_EXT1, `ILPC_BIT_KEYPAD,
      `ILPC_BIT_CMP1, `ILPC_BIT_TIMER1, `ILPC_BIT_CMP2, `ILPC_BIT_SERIAL,
      `ILPC_BIT_PWM
   };
   // R16: vector per source
   localparam ilpc_addr_t SRC_VEC [0:12] = '{
      `ILPC_VEC_EXT0, `ILPC_VEC_BROWNOUT, `ILPC_VEC_WDOG, `ILPC_VEC_TIMER0,
      `ILPC_VEC_I2C, `ILPC_VEC_CONV, `ILPC_VEC_EXT1, `ILPC_VEC_KEYPAD,
      `ILPC_VEC_CMP1, `ILPC_VEC_TIMER1, `ILPC_VEC_CMP2, `ILPC_VEC_SERIAL,
      `ILPC_VEC_PWM
   };
   localparam logic [12:0] GROUP_B = `ILPC_GROUP_B_MASK;

   logic [7:0] en_a_q;
   logic [7:0] en_b_q;
   logic [7:0] prio_low_a_q;
   logic [7:0] prio_high_a_q;
   logic [7:0] prio_low_b_q;
   logic [7:0] prio_high_b_q;
   logic [3:0] in_service_q;
   logic [3:0] in_service_d;
   logic [2:0] busy_q;
   logic call_req_q;
   ilpc_addr_t call_vector_q;
   ilpc_level_t call_level_q;
   logic [12:0] flag_clear_q;
   logic [12:0] flag_clear_d;
   logic wake_q;
   logic [7:0] sfr_rdata_q;
   logic [7:0] sfr_rdata_d;

   wire logic [12:0] en_vec;
   wire logic [12:0] live;
   wire ilpc_level_t lvl [0:12];
   wire logic [12:0] at_lvl [0:3];
   wire logic global_en;
   wire logic any_req;
   wire logic busy;
   wire logic call_issue;
   wire logic [3:0] set_mask;
   wire logic [3:0] return_from_interrupt_mask;
   wire logic [12:0] wake_src;

   ilpc_level_t win_level;
   logic [3:0] win_idx;
   ilpc_level_t act_level;
   logic act_valid;

   // R19: global enable masks all
   assign global_en = en_a_q[`ILPC_BIT_GLOBAL];

   for (genvar i = 0; i < 13; i++) begin : g_src
      // R19: per-source enable bit
      assign en_vec[i] = GROUP_B[i] ? en_b_q[SRC_BIT[i]] : en_a_q[SRC_BIT[i]];
      // R02: paired bits per source
      // R01: high bit, low bit form level
      assign lvl[i] = GROUP_B[i] ? {prio_high_b_q[SRC_BIT[i]], prio_low_b_q[SRC_BIT[i]]}
                                 : {prio_high_a_q[SRC_BIT[i]], prio_low_a_q[SRC_BIT[i]]};
      // R10: live flags only, no latching
      assign live[i] = src_flags[i] & en_vec[i] & global_en;
      for (genvar l = 0; l < 4; l++) begin : g_lvl
         assign at_lvl[l][i] = live[i] & (lvl[i] == ilpc_level_t'(l));
      end
   end

   assign any_req = |live;

   // R04: highest pending level wins
   always_comb begin
      win_level = 2'h0;
      for (int l = 0; l < 4; l++) begin
         if (|at_lvl[l]) begin
            win_level = ilpc_level_t'(l);
         end
      end
   end

   // R05: lowest rank index wins tie
   always_comb begin
      win_idx = 4'h0;
      for (int i = 12; i >= 0; i--) begin
         if (at_lvl[win_level][i]) begin
            win_idx = 4'(i);
         end
      end
   end

   // R22: highest active in-service level
   always_comb begin
      act_level = 2'h0;
      act_valid = 1'b0;
      for (int l = 0; l < 4; l++) begin
         if (in_service_q[l]) begin
            act_level = ilpc_level_t'(l);
            act_valid = 1'b1;
         end
      end
   end

   // R21: no new poll while a call runs
   assign busy = busy_q != 3'h0;

   // R06: poll on the sampling tick
   // R08: last machine cycle only
   // R09: blocked instructions suppress call
   // R03: strictly higher level preempts
   // R07: equal or higher in service blocks
   assign call_issue = core.mc_tick & core.last_cycle & ~core.block_call & ~busy & any_req
                     & (~act_valid | (win_level > act_level));

   // R22: set on call, clear on return-from-interrupt
   assign set_mask = call_issue ? 4'(4'h1 << win_level) : 4'h0;
   // R17: return-from-interrupt ends top level
   assign return_from_interrupt_mask = (core.return_from_interrupt_exec & act_valid) ? 4'(4'h1 << act_level) : 4'h0;
   // R18: plain return has no input here
   assign in_service_d = (in_service_q & ~return_from_interrupt_mask) | set_mask;

   // R11: timer flags cleared on vectoring
   // R12: external flags cleared if edge mode
   // R13: serial flags never cleared
   // R14: watchdog flag never cleared
   always_comb begin
      flag_clear_d = 13'h0000;
      if (call_issue) begin
         flag_clear_d[`ILPC_RANK_TIMER0] = win_idx == 4'(`ILPC_RANK_TIMER0);
         flag_clear_d[`ILPC_RANK_TIMER1] = win_idx == 4'(`ILPC_RANK_TIMER1);
         flag_clear_d[`ILPC_RANK_EXT0] = (win_idx == 4'(`ILPC_RANK_EXT0)) & ext0_edge_mode;
         flag_clear_d[`ILPC_RANK_EXT1] = (win_idx == 4'(`ILPC_RANK_EXT1)) & ext1_edge_mode;
      end
   end

   // R20: wake sources, watchdog and converter need RC
   assign wake_src = `ILPC_WAKE_ALWAYS | (rc_clock_sel ? `ILPC_WAKE_RC_ONLY : 13'h0000);

   always_comb begin
      unique case (core.sfr_addr)
         `ILPC_SFR_EN_A: sfr_rdata_d = en_a_q;
         `ILPC_SFR_EN_B: sfr_rdata_d = en_b_q;
         `ILPC_SFR_PRIO_LOW_A: sfr_rdata_d = prio_low_a_q;
         `ILPC_SFR_PRIO_HIGH_A: sfr_rdata_d = prio_high_a_q;
         `ILPC_SFR_PRIO_LOW_B: sfr_rdata_d = prio_low_b_q;
         `ILPC_SFR_PRIO_HIGH_B: sfr_rdata_d = prio_high_b_q;
         default: sfr_rdata_d = 8'h00;
      endcase
   end

   // Register writes from the core
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_a_q <= `ILPC_RST_EN;
         en_b_q <= `ILPC_RST_EN;
         prio_low_a_q <= `ILPC_RST_PRIO;
         prio_high_a_q <= `ILPC_RST_PRIO;
         prio_low_b_q <= `ILPC_RST_PRIO;
         prio_high_b_q <= `ILPC_RST_PRIO;
      end else if (core.sfr_we) begin
         en_a_q <= (core.sfr_addr == `ILPC_SFR_EN_A) ? core.sfr_wdata : en_a_q;
         en_b_q <= (core.sfr_addr == `ILPC_SFR_EN_B) ? core.sfr_wdata : en_b_q;
         prio_low_a_q <= (core.sfr_addr == `ILPC_SFR_PRIO_LOW_A) ? core.sfr_wdata
                                                                : prio_low_a_q;
         prio_high_a_q <= (core.sfr_addr == `ILPC_SFR_PRIO_HIGH_A) ? core.sfr_wdata
                                                                  : prio_high_a_q;
         prio_low_b_q <= (core.sfr_addr == `ILPC_SFR_PRIO_LOW_B) ? core.sfr_wdata
                                                                : prio_low_b_q;
         prio_high_b_q <= (core.sfr_addr == `ILPC_SFR_PRIO_HIGH_B) ? core.sfr_wdata
                                                                  : prio_high_b_q;
      end
   end

   // Call issue and in-service tracking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_service_q <= 4'h0;
         busy_q <= 3'h0;
         call_req_q <= 1'b0;
         call_vector_q <= 16'h0000;
         call_level_q <= 2'h0;
         flag_clear_q <= 13'h0000;
         wake_q <= 1'b0;
         sfr_rdata_q <= 8'h00;
      end else begin
         in_service_q <= in_service_d;
         call_req_q <= call_issue;
         flag_clear_q <= flag_clear_d;
         wake_q <= power_down & |(live & wake_src);
         sfr_rdata_q <= sfr_rdata_d;
         // R21: four machine cycles of call
         if (call_issue) begin
            busy_q <= `ILPC_CALL_MCYCLES;
         end else if (busy && core.mc_tick) begin
            busy_q <= busy_q - 3'h1;
         end
         // R15: vector handed to the core
         if (call_issue) begin
            call_vector_q <= SRC_VEC[win_idx];
            call_level_q <= win_level;
         end
      end
   end

   assign core.call_req = call_req_q;
   assign core.call_vector = call_vector_q;
   assign core.call_level = call_level_q;
   assign core.in_service = in_service_q;
   assign core.sfr_rdata = sfr_rdata_q;
   assign flag_clear = flag_clear_q;
   assign wake_req = wake_q;

endmodule : ilpc_ctrl

// >>> core/ilpc_if.sv
`timescale 1ns/1ps

interface ilpc_if;
   import ilpc_pkg::*;
   // Core sequencer to controller
   logic mc_tick;
   logic last_cycle;
   logic block_call;
   logic return_from_interrupt_exec;
   logic sfr_we;
   logic [2:0] sfr_addr;
   logic [7:0] sfr_wdata;
   // Controller to core sequencer
   logic call_req;
   ilpc_addr_t call_vector;
   ilpc_level_t call_level;
   logic [3:0] in_service;
   logic [7:0] sfr_rdata;

   modport ctrl (
      input mc_tick, last_cycle, block_call, return_from_interrupt_exec, sfr_we, sfr_addr, sfr_wdata,
      output call_req, call_vector, call_level, in_service, sfr_rdata
   );
   modport core (
      output mc_tick, last_cycle, block_call, return_from_interrupt_exec, sfr_we, sfr_addr, sfr_wdata,
      input call_req, call_vector, call_level, in_service, sfr_rdata
   );
endinterface : ilpc_if

// >>> core/ilpc_map.svh
`ifndef ILPC_MAP_SVH
`define ILPC_MAP_SVH

// Controller register indices on the core's register port
`define ILPC_SFR_EN_A 3'h0
`define ILPC_SFR_EN_B 3'h1
`define ILPC_SFR_PRIO_LOW_A 3'h2
`define ILPC_SFR_PRIO_HIGH_A 3'h3
`define ILPC_SFR_PRIO_LOW_B 3'h4
`define ILPC_SFR_PRIO_HIGH_B 3'h5

// Register reset values
`define ILPC_RST_EN 8'h00
`define ILPC_RST_PRIO 8'h00

// Bit positions in group A (enable and priority)
`define ILPC_BIT_EXT0 0
`define ILPC_BIT_TIMER0 1
`define ILPC_BIT_EXT1 2
`define ILPC_BIT_TIMER1 3
`define ILPC_BIT_SERIAL 4
`define ILPC_BIT_BROWNOUT 5
`define ILPC_BIT_CONV 6
`define ILPC_BIT_GLOBAL 7
// Bit positions in group B
`define ILPC_BIT_I2C 0
`define ILPC_BIT_KEYPAD 1
`define ILPC_BIT_CMP1 2
`define ILPC_BIT_CMP2 3
`define ILPC_BIT_WDOG 4
`define ILPC_BIT_PWM 5

// Arbitration rank of each source (0 first); also its flag index
`define ILPC_RANK_EXT0 0
`define ILPC_RANK_BROWNOUT 1
`define ILPC_RANK_WDOG 2
`define ILPC_RANK_TIMER0 3
`define ILPC_RANK_I2C 4
`define ILPC_RANK_CONV 5
`define ILPC_RANK_EXT1 6
`define ILPC_RANK_KEYPAD 7
`define ILPC_RANK_CMP1 8
`define ILPC_RANK_TIMER1 9
`define ILPC_RANK_CMP2 10
`define ILPC_RANK_SERIAL 11
`define ILPC_RANK_PWM 12

// Sources kept in group B, by rank index
`define ILPC_GROUP_B_MASK 13'h1594
// Wake sources in power-down, by rank index
`define ILPC_WAKE_ALWAYS 13'h05C3
`define ILPC_WAKE_RC_ONLY 13'h0024

// Vector addresses
`define ILPC_VEC_EXT0 16'h0003
`define ILPC_VEC_TIMER0 16'h000B
`define ILPC_VEC_EXT1 16'h0013
`define ILPC_VEC_TIMER1 16'h001B
`define ILPC_VEC_SERIAL 16'h0023
`define ILPC_VEC_BROWNOUT 16'h002B
`define ILPC_VEC_I2C 16'h0033
`define ILPC_VEC_KEYPAD 16'h003B
`define ILPC_VEC_CMP2 16'h0043
`define ILPC_VEC_WDOG 16'h0053
`define ILPC_VEC_CONV 16'h005B
`define ILPC_VEC_CMP1 16'h0063
`define ILPC_VEC_PWM 16'h0073

// Timing counts
`define ILPC_MC_CLOCKS 2'h3
`define ILPC_CALL_MCYCLES 3'h4

// Core-end APB register offsets
`define ILPC_APB_CTRL 8'h00
`define ILPC_APB_INSTR 8'h04
`define ILPC_APB_STATUS 8'h08
`define ILPC_APB_CALLS 8'h0C
`define ILPC_RST_INSTR_LEN 4'h1

`endif

// >>> core/ilpc_pkg.sv
`include "ilpc_map.svh"

package ilpc_pkg;
   typedef logic [1:0] ilpc_level_t;
   typedef logic [15:0] ilpc_addr_t;
   typedef enum logic [1:0] {
      ILPC_OP_PLAIN = 2'b00,
      ILPC_OP_SFR_WRITE = 2'b01,
      ILPC_OP_RETURN_FROM_INTERRUPT = 2'b10,
      ILPC_OP_RET = 2'b11
   } ilpc_op_t;
   typedef enum logic {
      ILPC_EXEC = 1'b0,
      ILPC_CALL = 1'b1
   } ilpc_core_state_t;
endpackage : ilpc_pkg
